// ---- src/lsa_top.sv ----
// Legacy segment address unit: mode tracking, segment loads, address formation
//
// Summary of operation
// R1: Reset and power-up always leave the unit in real-address mode.
// R2: Real mode address is selector shifted left four plus 16-bit offset, 20 bits.
// R3: Real mode segments span 64K, sit on 16-byte boundaries, base is selector*16.
// R4: Real mode selector load updates selector and base; limit, attributes kept.
// R5: Real or virtual-8086 far transfer writes code selector and base selector*16; limit, attributes kept.
// R6: Real mode never consults descriptor tables or task-state segment for addressing.
// R7: Virtual-8086 loads and bases behave as real mode; reach limited to 1MB.
// R8: Interrupt or exception in virtual-8086 switches to protected mode.
// R9: Ten segment registers, six user and four system, with base, limit, attributes.
// R10: 64-bit mode gives a flat 64-bit space; only the two auxiliary segments still add their bases.
// R11: Compatibility mode keeps legacy protected-mode segmentation unchanged.
// R12: System-segment registers keep locating tables even in 64-bit mode.
// R13: The pipeline presents the operating mode as an encoded input.
`timescale 1ns/10ps
`default_nettype none

module lsa_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        modeReq,
  input  wire logic [1:0]  modeIn,
  input  wire logic        intEvent,
  input  wire logic        selLoad,
  input  wire logic [2:0]  selSeg,
  input  wire logic [15:0] selVal,
  input  wire logic        farXfer,
  input  wire logic [15:0] farSel,
  input  wire logic        descLoad,
  input  wire logic [2:0]  descSeg,
  input  wire logic [15:0] descSel,
  input  wire logic [63:0] descBase,
  input  wire logic [31:0] descLimit,
  input  wire logic [11:0] descAttr,
  input  wire logic        sysLoad,
  input  wire logic [1:0]  sysIdx,
  input  wire logic [63:0] sysBase,
  input  wire logic [31:0] sysLimit,
  input  wire logic        addrReq,
  input  wire logic [2:0]  addrSeg,
  input  wire logic [63:0] effAddr,
  input  wire logic [1:0]  tblSel,
  output logic      [63:0] physAddr,
  output logic             addrValid,
  output logic      [1:0]  curMode,
  output logic             v86Exit,
  output logic      [63:0] tableBase,
  output logic      [31:0] tableLimit
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode tracker
  lsa_pkg::lsa_mode_t modeQ;
  lsa_pkg::lsa_mode_t mode_d;
  logic [1:0]         modeEnc;
  logic [1:0]         curMode_d;
  logic               v86Exit_d;
  logic               legacyAddr;

  // Encoded view of the current state
  always_comb
  begin
    case (modeQ)
      lsa_pkg::MD_REAL:   modeEnc = lsa_pkg::MODE_REAL;
      lsa_pkg::MD_V86:    modeEnc = lsa_pkg::MODE_V86;
      lsa_pkg::MD_COMPAT: modeEnc = lsa_pkg::MODE_COMPAT;
      default:            modeEnc = lsa_pkg::MODE_LONG;
    endcase
  end

  assign legacyAddr = (modeQ == lsa_pkg::MD_REAL) || (modeQ == lsa_pkg::MD_V86);

  // Interrupt out of virtual-8086 beats any mode request in the same cycle
  always_comb
  begin
    mode_d    = modeQ;
    v86Exit_d = 1'b0;
    if (modeQ == lsa_pkg::MD_V86 && intEvent)
    begin
      mode_d    = lsa_pkg::MD_COMPAT; // R8
      v86Exit_d = 1'b1;
    end
    else if (modeReq)
    begin
      case (modeIn) // R13
        lsa_pkg::MODE_REAL:   mode_d = lsa_pkg::MD_REAL;
        lsa_pkg::MODE_V86:    mode_d = lsa_pkg::MD_V86;
        lsa_pkg::MODE_COMPAT: mode_d = lsa_pkg::MD_COMPAT;
        default:              mode_d = lsa_pkg::MD_LONG;
      endcase
    end
    case (mode_d)
      lsa_pkg::MD_REAL:   curMode_d = lsa_pkg::MODE_REAL;
      lsa_pkg::MD_V86:    curMode_d = lsa_pkg::MODE_V86;
      lsa_pkg::MD_COMPAT: curMode_d = lsa_pkg::MODE_COMPAT;
      default:            curMode_d = lsa_pkg::MODE_LONG;
    endcase
  end

  // Reset always lands in real mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      modeQ   <= lsa_pkg::MD_REAL; // R1
      curMode <= lsa_pkg::MODE_REAL;
      v86Exit <= 1'b0;
    end
    else
    begin
      modeQ   <= mode_d;
      curMode <= curMode_d;
      v86Exit <= v86Exit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single write port into the segment file, fixed priority:
  // far transfer, system load, descriptor load, selector load.
  // Losers of a same-cycle clash are dropped; the pipeline serialises them.
  logic        wrEn;
  logic [3:0]  wrIdx;
  logic        wrSelEn;
  logic        wrLimAttrEn;
  logic [15:0] wrSel;
  logic [63:0] wrBase;
  logic [31:0] wrLimit;
  logic [11:0] wrAttr;
  logic        selOk;
  logic        descOk;

  // Paragraph loads only in real or virtual-8086; descriptors only outside them
  assign selOk  = selLoad && legacyAddr && ({1'b0, selSeg} < 4'(lsa_pkg::NUM_USER));
  assign descOk = descLoad && !legacyAddr && ({1'b0, descSeg} < 4'(lsa_pkg::NUM_USER)); // R6

  always_comb
  begin
    wrEn        = 1'b0;
    wrIdx       = lsa_pkg::SEG_CODE;
    wrSelEn     = 1'b0;
    wrLimAttrEn = 1'b0;
    wrSel       = selVal;
    wrBase      = {44'h0, selVal, 4'h0};
    wrLimit     = descLimit;
    wrAttr      = descAttr;
    if (farXfer && legacyAddr)
    begin
      wrEn    = 1'b1; // R5
      wrIdx   = lsa_pkg::SEG_CODE;
      wrSelEn = 1'b1;
      wrSel   = farSel;
      wrBase  = {44'h0, farSel, 4'h0};
    end
    else if (sysLoad)
    begin
      // Table registers load in every mode, 64-bit included
      wrEn        = 1'b1; // R12
      wrIdx       = lsa_pkg::SEG_GLOBAL_TBL + {2'h0, sysIdx};
      wrLimAttrEn = 1'b1;
      wrBase      = sysBase;
      wrLimit     = sysLimit;
      wrAttr      = lsa_pkg::RST_ATTR;
    end
    else if (descOk)
    begin
      wrEn        = 1'b1; // R11
      wrIdx       = {1'b0, descSeg};
      wrSelEn     = 1'b1;
      wrLimAttrEn = 1'b1;
      wrSel       = descSel;
      wrBase      = descBase;
    end
    else if (selOk)
    begin
      // Same handling in real and virtual-8086 mode
      wrEn    = 1'b1; // R4 R7
      wrIdx   = {1'b0, selSeg};
      wrSelEn = 1'b1;
      wrBase  = {44'h0, selVal, 4'h0}; // R3
    end
  end

  logic [lsa_pkg::NUM_SEG-1:0][15:0] segSel;
  logic [lsa_pkg::NUM_SEG-1:0][63:0] segBase;
  logic [lsa_pkg::NUM_SEG-1:0][31:0] segLimit;
  logic [lsa_pkg::NUM_SEG-1:0][11:0] segAttr;

  // Ten registers, six user then four system
  lsa_seg_file uSegFile ( // R9
    .clk         (clk),
    .rst         (rst),
    .wrEn        (wrEn),
    .wrIdx       (wrIdx),
    .wrSelEn     (wrSelEn),
    .wrLimAttrEn (wrLimAttrEn),
    .wrSel       (wrSel),
    .wrBase      (wrBase),
    .wrLimit     (wrLimit),
    .wrAttr      (wrAttr),
    .segSel      (segSel),
    .segBase     (segBase),
    .segLimit    (segLimit),
    .segAttr     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address formation, registered one cycle after the request
  logic [3:0]  rdIdx;
  logic [63:0] linAddr;
  logic [63:0] physAddr_d;
  logic        addrValid_d;
  logic [63:0] tableBase_d;
  logic [31:0] tableLimit_d;
  logic [3:0]  tblIdx;

  // Out-of-range user index falls back to the code segment
  assign rdIdx  = (addrSeg > 3'h5) ? lsa_pkg::SEG_CODE : {1'b0, addrSeg};
  assign tblIdx = lsa_pkg::SEG_GLOBAL_TBL + {2'h0, tblSel};

  lsa_addr_gen uAddrGen ( // R2 R7 R10 R11
    .mode    (modeEnc),
    .segIdx  (rdIdx),
    .sel     (segSel[rdIdx]),
    .base    (segBase[rdIdx]),
    .effAddr (effAddr),
    .linAddr (linAddr)
  );

  // Hold the last address between requests
  always_comb
  begin
    physAddr_d   = addrReq ? linAddr : physAddr;
    addrValid_d  = addrReq;
    tableBase_d  = segBase[tblIdx];
    tableLimit_d = segLimit[tblIdx];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      physAddr   <= 64'h0;
      addrValid  <= 1'b0;
      tableBase  <= lsa_pkg::RST_BASE;
      tableLimit <= lsa_pkg::RST_LIMIT;
    end
    else
    begin
      physAddr   <= physAddr_d;
      addrValid  <= addrValid_d;
      tableBase  <= tableBase_d; // R12
      tableLimit <= tableLimit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [19:0] realExp;
  logic [31:0] compatExp;
  assign realExp   = {segSel[rdIdx], 4'h0} + {4'h0, effAddr[15:0]};
  assign compatExp = segBase[rdIdx][31:0] + effAddr[31:0];

  property p_resetReal;
    @(posedge clk) disable iff (rst)
    $past(rst) |-> (modeQ == lsa_pkg::MD_REAL && curMode == lsa_pkg::MODE_REAL);
  endproperty
  a_resetReal: assert property (p_resetReal) else $error("not real after reset"); // R1

  property p_realAddr;
    @(posedge clk) disable iff (rst)
    (addrReq && legacyAddr) |=> (addrValid && physAddr[63:20] == 44'h0
                                 && physAddr[19:0] == $past(realExp));
  endproperty
  a_realAddr: assert property (p_realAddr) else $error("real address wrong"); // R2

  property p_selLoad;
    @(posedge clk) disable iff (rst)
    (selOk && !farXfer && !sysLoad) |=>
      (segBase[$past(selSeg)] == {44'h0, $past(selVal), 4'h0}
       && segSel[$past(selSeg)] == $past(selVal)
       && $stable(segLimit));
  endproperty
  a_selLoad: assert property (p_selLoad) else $error("selector load wrong"); // R4

  property p_farXfer;
    @(posedge clk) disable iff (rst)
    (farXfer && legacyAddr) |=>
      (segBase[0][19:0] == {$past(farSel), 4'h0} && segBase[0][3:0] == 4'h0
       && segLimit[0] == $past(segLimit[0]));
  endproperty
  a_farXfer: assert property (p_farXfer) else $error("far transfer wrong"); // R5

  property p_realNoDesc;
    @(posedge clk) disable iff (rst)
    (legacyAddr && descLoad && !sysLoad) |=> $stable(segLimit);
  endproperty
  a_realNoDesc: assert property (p_realNoDesc) else $error("descriptor used"); // R6

  property p_v86Int;
    @(posedge clk) disable iff (rst)
    (modeQ == lsa_pkg::MD_V86 && intEvent) |=>
      (modeQ == lsa_pkg::MD_COMPAT && v86Exit ##1 !v86Exit);
  endproperty
  a_v86Int: assert property (p_v86Int) else $error("no exit from v86"); // R8

  property p_flat;
    @(posedge clk) disable iff (rst)
    (addrReq && modeQ == lsa_pkg::MD_LONG && addrSeg < 3'h4) |=>
      physAddr == $past(effAddr);
  endproperty
  a_flat: assert property (p_flat) else $error("64-bit not flat"); // R10

  property p_compat;
    @(posedge clk) disable iff (rst)
    (addrReq && modeQ == lsa_pkg::MD_COMPAT) |=> physAddr == {32'h0, $past(compatExp)};
  endproperty
  a_compat: assert property (p_compat) else $error("compat address wrong"); // R11

  property p_sysLoad;
    @(posedge clk) disable iff (rst)
    (sysLoad && !(farXfer && legacyAddr) && tblSel == sysIdx) ##1 (tblSel == $past(tblSel))
      |=> (tableBase == $past(sysBase, 2) && tableLimit == $past(sysLimit, 2));
  endproperty
  a_sysLoad: assert property (p_sysLoad) else $error("table register lost"); // R12

  property p_coverV86Exit;
    @(posedge clk) disable iff (rst) modeQ == lsa_pkg::MD_V86 ##1 v86Exit;
  endproperty
  c_v86Exit: cover property (p_coverV86Exit);

  property p_coverRealLoadUse;
    @(posedge clk) disable iff (rst) (selOk && !farXfer && !sysLoad) ##1 addrReq;
  endproperty
  c_realLoadUse: cover property (p_coverRealLoadUse);

  property p_coverLongAux;
    @(posedge clk) disable iff (rst)
    addrReq && modeQ == lsa_pkg::MD_LONG && addrSeg == 3'h4;
  endproperty
  c_longAux: cover property (p_coverLongAux);

endmodule : lsa_top

`default_nettype wire

// ---- common/lsa_pkg.sv ----
// Shared constants and types of the legacy segment address unit
package lsa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode encoding presented by the pipeline
  localparam logic [1:0] MODE_REAL   = 2'h0;
  localparam logic [1:0] MODE_V86    = 2'h1;
  localparam logic [1:0] MODE_COMPAT = 2'h2;
  localparam logic [1:0] MODE_LONG   = 2'h3;

  // One-hot mode tracker states
  typedef enum logic [3:0] {
    MD_REAL   = 4'b0001,
    MD_V86    = 4'b0010,
    MD_COMPAT = 4'b0100,
    MD_LONG   = 4'b1000
  } lsa_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // Segment register indices: six user segments, then four system segments
  localparam int         NUM_SEG        = 10;
  localparam int         NUM_USER       = 6;
  localparam logic [3:0] SEG_CODE       = 4'h0;
  localparam logic [3:0] SEG_DATA       = 4'h1;
  localparam logic [3:0] SEG_EXTRA      = 4'h2;
  localparam logic [3:0] SEG_STACK      = 4'h3;
  localparam logic [3:0] SEG_AUX_ONE    = 4'h4;
  localparam logic [3:0] SEG_AUX_TWO    = 4'h5;
  localparam logic [3:0] SEG_GLOBAL_TBL = 4'h6;
  localparam logic [3:0] SEG_LOCAL_TBL  = 4'h7;
  localparam logic [3:0] SEG_INT_TBL    = 4'h8;
  localparam logic [3:0] SEG_TASK_STATE = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths and reset values
  localparam int          SEL_W      = 16;
  localparam int          BASE_W     = 64;
  localparam int          LIMIT_W    = 32;
  localparam int          ATTR_W     = 12;
  localparam int          REAL_AW    = 20;
  localparam int          PARA_SHIFT = 4;
  localparam logic [15:0] RST_SEL    = 16'h0000;
  localparam logic [63:0] RST_BASE   = 64'h0000_0000_0000_0000;
  localparam logic [31:0] RST_LIMIT  = 32'h0000_ffff;
  localparam logic [11:0] RST_ATTR   = 12'h093;

endpackage : lsa_pkg

// ---- src/lsa_seg_file.sv ----
// Ten segment registers: selector, base, limit and attributes each
`timescale 1ns/10ps
`default_nettype none

module lsa_seg_file (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       wrEn,
  input  wire logic [3:0]                 wrIdx,
  input  wire logic                       wrSelEn,
  input  wire logic                       wrLimAttrEn,
  input  wire logic [15:0]                wrSel,
  input  wire logic [63:0]                wrBase,
  input  wire logic [31:0]                wrLimit,
  input  wire logic [11:0]                wrAttr,
  output logic      [lsa_pkg::NUM_SEG-1:0][15:0] segSel,
  output logic      [lsa_pkg::NUM_SEG-1:0][63:0] segBase,
  output logic      [lsa_pkg::NUM_SEG-1:0][31:0] segLimit,
  output logic      [lsa_pkg::NUM_SEG-1:0][11:0] segAttr
);

  ////////////////////////////////////////////////////////////////////////////
  // One register set per segment; only the addressed entry moves
  for (genvar i = 0; i < lsa_pkg::NUM_SEG; i++)
  begin : gSeg
    logic        hit;
    logic [15:0] sel_d;
    logic [63:0] base_d;
    logic [31:0] limit_d;
    logic [11:0] attr_d;

    assign hit = wrEn && (wrIdx == 4'(i));

    // Limit and attributes stay put unless a descriptor or system load raises wrLimAttrEn
    always_comb
    begin
      sel_d   = segSel[i];
      base_d  = segBase[i];
      limit_d = segLimit[i];
      attr_d  = segAttr[i];
      if (hit)
      begin
        base_d = wrBase;
        if (wrSelEn)
          sel_d = wrSel;
        if (wrLimAttrEn)
        begin
          limit_d = wrLimit;
          attr_d  = wrAttr;
        end
      end
    end

    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        segSel[i]   <= lsa_pkg::RST_SEL;
        segBase[i]  <= lsa_pkg::RST_BASE;
        segLimit[i] <= lsa_pkg::RST_LIMIT;
        segAttr[i]  <= lsa_pkg::RST_ATTR;
      end
      else
      begin
        segSel[i]   <= sel_d;
        segBase[i]  <= base_d;
        segLimit[i] <= limit_d;
        segAttr[i]  <= attr_d;
      end
    end
  end

endmodule : lsa_seg_file

`default_nettype wire

// ---- src/lsa_addr_gen.sv ----
// Combinational linear address formation per operating mode
`timescale 1ns/10ps
`default_nettype none

module lsa_addr_gen (
  input  wire logic [1:0]  mode,
  input  wire logic [3:0]  segIdx,
  input  wire logic [15:0] sel,
  input  wire logic [63:0] base,
  input  wire logic [63:0] effAddr,
  output logic      [63:0] linAddr
);

  logic [19:0] realSum;
  logic [31:0] compatSum;

  ////////////////////////////////////////////////////////////////////////////
  // Paragraph-scaled selector plus 16-bit offset; carry out of 20 bits wraps
  assign realSum   = {sel, 4'h0} + {4'h0, effAddr[15:0]};
  assign compatSum = base[31:0] + effAddr[31:0];

  // Mode decides the translation; descriptor tables are never read here
  always_comb
  begin
    case (mode)
      lsa_pkg::MODE_REAL,
      lsa_pkg::MODE_V86:    linAddr = {44'h0, realSum};
      lsa_pkg::MODE_COMPAT: linAddr = {32'h0, compatSum};
      default:
      begin
        // Flat space, but the two auxiliary segments keep their bases
        if (segIdx == lsa_pkg::SEG_AUX_ONE || segIdx == lsa_pkg::SEG_AUX_TWO)
          linAddr = base + effAddr;
        else
          linAddr = effAddr;
      end
    endcase
  end

endmodule : lsa_addr_gen

`default_nettype wire

// ---- verif/lsa_pipe_model.sv ----
// Pipeline-side model that presents modes, loads and address requests
`timescale 1ns/10ps
`default_nettype none

module lsa_pipe_model (
  input  wire logic        clk,
  output logic             modeReq,
  output logic      [1:0]  modeIn,
  output logic             intEvent,
  output logic             selLoad,
  output logic      [2:0]  selSeg,
  output logic      [15:0] selVal,
  output logic             farXfer,
  output logic      [15:0] farSel,
  output logic             descLoad,
  output logic      [2:0]  descSeg,
  output logic      [15:0] descSel,
  output logic      [63:0] descBase,
  output logic      [31:0] descLimit,
  output logic      [11:0] descAttr,
  output logic             sysLoad,
  output logic      [1:0]  sysIdx,
  output logic      [63:0] sysBase,
  output logic      [31:0] sysLimit,
  output logic             addrReq,
  output logic      [2:0]  addrSeg,
  output logic      [63:0] effAddr,
  output logic      [1:0]  tblSel
);
  ////////////////////////////////////////
  // Idle at time zero: no strobe raised
  initial
  begin
    {modeReq, intEvent, selLoad, farXfer, descLoad, sysLoad, addrReq} = '0;
    {modeIn, selSeg, selVal, farSel, descSeg, descSel, descBase} = '0;
    {descLimit, descAttr, sysIdx, sysBase, sysLimit, addrSeg, effAddr, tblSel} = '0;
  end

  // One-cycle strobe, then data scrambled so stale values never look valid
  task automatic drop();
    @(negedge clk);
    {modeReq, intEvent, selLoad, farXfer, descLoad, sysLoad, addrReq} = '0;
    {modeIn, selVal, farSel, descSel, descBase, sysBase, sysLimit, effAddr} =
      ~{modeIn, selVal, farSel, descSel, descBase, sysBase, sysLimit, effAddr};
  endtask : drop

  ////////////////////////////////////////
  // Request tasks, each starting at a falling edge
  task automatic mode(input logic [1:0] m);
    @(negedge clk);
    modeIn  = m;
    modeReq = 1'b1;
    drop();
  endtask : mode

  task automatic intr();
    @(negedge clk);
    intEvent = 1'b1;
    drop();
  endtask : intr

  task automatic selLd(input logic [2:0] s, input logic [15:0] v);
    @(negedge clk);
    selSeg  = s;
    selVal  = v;
    selLoad = 1'b1;
    drop();
  endtask : selLd

  task automatic far(input logic [15:0] v);
    @(negedge clk);
    farSel  = v;
    farXfer = 1'b1;
    drop();
  endtask : far

  task automatic desc(input logic [2:0] s, input logic [63:0] b);
    @(negedge clk);
    descSeg   = s;
    descSel   = b[15:0];
    descBase  = b;
    descLimit = 32'hffff_ffff;
    descAttr  = 12'h093;
    descLoad  = 1'b1;
    drop();
  endtask : desc

  task automatic sys(input logic [1:0] i, input logic [63:0] b, input logic [31:0] l);
    @(negedge clk);
    sysIdx   = i;
    sysBase  = b;
    sysLimit = l;
    sysLoad  = 1'b1;
    drop();
  endtask : sys

  task automatic addr(input logic [2:0] s, input logic [63:0] e);
    @(negedge clk);
    addrSeg = s;
    effAddr = e;
    addrReq = 1'b1;
    drop();
  endtask : addr

  // Table register select, called at a falling edge
  task automatic show(input logic [1:0] i);
    tblSel = i;
  endtask : show
endmodule : lsa_pipe_model
`default_nettype wire

// ---- verif/lsa_top_tb.sv ----
// Self-checking bench of the legacy segment address unit
`timescale 1ns/10ps
`default_nettype none

module lsa_top_tb;
  logic        clk;
  logic        rst;
  logic        modeReq, intEvent, selLoad, farXfer, descLoad, sysLoad, addrReq;
  logic [1:0]  modeIn, sysIdx, tblSel, curMode;
  logic [2:0]  selSeg, descSeg, addrSeg;
  logic [15:0] selVal, farSel, descSel;
  logic [63:0] descBase, sysBase, effAddr, physAddr, tableBase;
  logic [31:0] descLimit, sysLimit, tableLimit;
  logic [11:0] descAttr;
  logic        addrValid, v86Exit;
  int          miscompares = 0;
  int          checksDone  = 0;
  int          cycles      = 0;
  logic [63:0] expQ[$];
  logic [15:0] sels[6];
  logic [63:0] ea;
  logic [63:0] b;
  logic [31:0] l;

  lsa_top lsa_top_i (.clk, .rst, .modeReq, .modeIn, .intEvent, .selLoad, .selSeg, .selVal,
    .farXfer, .farSel, .descLoad, .descSeg, .descSel, .descBase, .descLimit, .descAttr,
    .sysLoad, .sysIdx, .sysBase, .sysLimit, .addrReq, .addrSeg, .effAddr, .tblSel,
    .physAddr, .addrValid, .curMode, .v86Exit, .tableBase, .tableLimit);

  lsa_pipe_model lsa_pipe_model_i (.clk, .modeReq, .modeIn, .intEvent, .selLoad, .selSeg,
    .selVal, .farXfer, .farSel, .descLoad, .descSeg, .descSel, .descBase, .descLimit,
    .descAttr, .sysLoad, .sysIdx, .sysBase, .sysLimit, .addrReq, .addrSeg, .effAddr,
    .tblSel);

  initial clk = 1'b0;
  always #10 clk = ~clk;

  ////////////////////////////////////////
  // Compare, verdict and expected-address helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    checksDone++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Sum kept to 20 bits, so the top of the space wraps
  function automatic logic [63:0] realAddr(input logic [15:0] s, input logic [63:0] e);
    logic [19:0] a;
    a = {s, 4'h0} + e[15:0];
    return {44'h0, a};
  endfunction : realAddr

  task automatic reqAddr(input logic [2:0] s, input logic [63:0] e, input logic [63:0] x);
    expQ.push_back(x);
    lsa_pipe_model_i.addr(s, e);
  endtask : reqAddr

  // Each valid pulse retires the oldest expected address; looked at mid-cycle,
  // away from the edge that launches or ends the pulse
  always @(negedge clk)
  begin
    if (!rst && addrValid === 1'b1)
    begin
      if (expQ.size() == 0)
        check(physAddr, 64'hx, "unexpected address");
      else
        check(physAddr, expQ.pop_front(), "address");
    end
  end

  // Run takes about a hundred cycles; a hang ends it here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("ERROR %0t: timeout", $time);
      give_verdict();
    end
  end

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst = 1'b1;
    void'($urandom(60940));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check({62'h0, curMode}, {62'h0, lsa_pkg::MODE_REAL}, "mode after reset");
    check({32'h0, tableLimit}, 64'hffff, "table limit after reset");
    // Table registers hold junk; real mode must ignore them
    for (int i = 0; i < 4; i++)
      lsa_pipe_model_i.sys(i[1:0], {$urandom, $urandom}, $urandom);
    for (int s = 0; s < 6; s++)
    begin
      sels[s] = 16'($urandom);
      lsa_pipe_model_i.selLd(s[2:0], sels[s]);
    end
    for (int s = 0; s < 6; s++)
    begin
      ea = {$urandom, $urandom};
      reqAddr(s[2:0], ea, realAddr(sels[s], ea));
    end
    lsa_pipe_model_i.selLd(3'h1, 16'hffff);
    reqAddr(3'h1, 64'hffff, 64'h0ffef);
    reqAddr(3'h4, 64'h0, realAddr(sels[4], 64'h0));
    // Descriptor load dropped in real mode; the extra segment check below sees it
    lsa_pipe_model_i.desc(3'h2, {$urandom, $urandom});
    // Far transfer touches the code segment only
    lsa_pipe_model_i.far(16'h1234);
    reqAddr(3'h0, 64'h5, 64'h12345);
    reqAddr(3'h6, 64'h5, 64'h12345);
    reqAddr(3'h2, 64'h0, realAddr(sels[2], 64'h0));
    // Virtual-8086 behaves as real until an interrupt
    lsa_pipe_model_i.mode(lsa_pkg::MODE_V86);
    check({62'h0, curMode}, {62'h0, lsa_pkg::MODE_V86}, "mode v86");
    lsa_pipe_model_i.selLd(3'h3, 16'hf000);
    reqAddr(3'h3, 64'h1_2345_ffff, 64'hfffff);
    lsa_pipe_model_i.far(16'h0100);
    reqAddr(3'h0, 64'h10, 64'h1010);
    lsa_pipe_model_i.intr();
    check({63'h0, v86Exit}, 64'h1, "exit pulse");
    check({62'h0, curMode}, {62'h0, lsa_pkg::MODE_COMPAT}, "mode after int");
    // Compatibility: descriptor base, selector loads dropped
    b = {$urandom, $urandom};
    lsa_pipe_model_i.desc(3'h1, b);
    lsa_pipe_model_i.selLd(3'h1, 16'h0040);
    ea = {$urandom, $urandom};
    reqAddr(3'h1, ea, {32'h0, b[31:0] + ea[31:0]});
    // 64-bit: flat except the two auxiliary bases
    lsa_pipe_model_i.mode(lsa_pkg::MODE_LONG);
    lsa_pipe_model_i.desc(3'h4, b);
    reqAddr(3'h1, ea, ea);
    reqAddr(3'h4, ea, b + ea);
    for (int i = 0; i < 4; i++)
    begin
      b = {$urandom, $urandom};
      l = $urandom;
      lsa_pipe_model_i.sys(i[1:0], b, l);
      lsa_pipe_model_i.show(i[1:0]);
      @(negedge clk);
      check(tableBase, b, "table base");
      check({32'h0, tableLimit}, {32'h0, l}, "table limit");
    end
    // Back to real by request: code segment keeps the last far selector
    lsa_pipe_model_i.mode(lsa_pkg::MODE_REAL);
    check({62'h0, curMode}, {62'h0, lsa_pkg::MODE_REAL}, "mode real");
    ea = {$urandom, $urandom};
    reqAddr(3'h0, ea, realAddr(16'h0100, ea));
    lsa_pipe_model_i.mode(lsa_pkg::MODE_COMPAT);
    check({62'h0, curMode}, {62'h0, lsa_pkg::MODE_COMPAT}, "mode compat");
    // Reset in mid-run returns to real mode with zero bases
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check({62'h0, curMode}, {62'h0, lsa_pkg::MODE_REAL}, "mode after reset");
    reqAddr(3'h5, 64'hbeef, 64'hbeef);
    repeat (3) @(negedge clk);
    check(64'(expQ.size()), 64'h0, "outstanding addresses");
    give_verdict();
  end
endmodule : lsa_top_tb
`default_nettype wire
